// *** rtl/bstp_map.svh ***
// Constants of the boundary scan test access port: widths, codes, field positions, reset values.
// Assumes inclusion by bstp_tap.sv only, not by bstp_pkg.sv; holds definitions only.
`ifndef BSTP_MAP_SVH
`define BSTP_MAP_SVH

// ------------------------------------------------------------
// Register widths
// ------------------------------------------------------------
`define BSTP_IR_W      3
`define BSTP_ID_W      32
`define BSTP_BSR_W     107

// ------------------------------------------------------------
// Instruction codes
// ------------------------------------------------------------
`define BSTP_IR_EXTEST 3'h0
`define BSTP_IR_IDCODE 3'h1
`define BSTP_IR_SAMPLE 3'h2
`define BSTP_IR_BYPASS 3'h7
`define BSTP_IR_CAPT   3'h1

// ------------------------------------------------------------
// Identification code fields
// ------------------------------------------------------------
`define BSTP_ID_REV_HI 31
`define BSTP_ID_REV_LO 28
`define BSTP_ID_PRT_HI 27
`define BSTP_ID_PRT_LO 12
`define BSTP_ID_VND_HI 11
`define BSTP_ID_VND_LO 1
`define BSTP_ID_FIX    0
`define BSTP_ID_FIXVAL 1'h1

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define BSTP_BYP_RST   1'h0
`define BSTP_BSR_RST   107'h0
`define BSTP_ID_RST    32'h0000_0000

`endif

// *** rtl/bstp_pkg.sv ***
// Types of the boundary scan test access port.
// Assumes nothing; uses no constants from the header.
package bstp_pkg;

	// ------------------------------------------------------------
	// Controller states
	// ------------------------------------------------------------
	typedef enum logic [3:0]
	{
		BSTP_TLR    = 4'h0,
		BSTP_RTI    = 4'h1,
		BSTP_SEL_DR = 4'h2,
		BSTP_CAP_DR = 4'h3,
		BSTP_SH_DR  = 4'h4,
		BSTP_EX1_DR = 4'h5,
		BSTP_PAU_DR = 4'h6,
		BSTP_EX2_DR = 4'h7,
		BSTP_UPD_DR = 4'h8,
		BSTP_SEL_IR = 4'h9,
		BSTP_CAP_IR = 4'ha,
		BSTP_SH_IR  = 4'hb,
		BSTP_EX1_IR = 4'hc,
		BSTP_PAU_IR = 4'hd,
		BSTP_EX2_IR = 4'he,
		BSTP_UPD_IR = 4'hf
	} bstp_state_t;

	// ------------------------------------------------------------
	// Data path selected by the instruction
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		BSTP_P_BYP = 2'h0,
		BSTP_P_ID  = 2'h1,
		BSTP_P_BSR = 2'h2
	} bstp_path_t;

	// Decoded controller strobes
	typedef struct packed
	{
		logic in_reset;
		logic capture_dr;
		logic shift_dr;
		logic update_dr;
		logic capture_ir;
		logic shift_ir;
		logic update_ir;
	} bstp_ctl_t;

endpackage

// *** rtl/bstp_tap.sv ***
// Boundary scan test access port: controller, instruction, bypass, identification and boundary registers.
// Assumes the test clock is free of core_clk; rst is the power-up reset; ring_in is the live I/O ring state.
`timescale 1ns/10ps
`include "bstp_map.svh"

module bstp_tap
#(
	parameter logic [3:0]  ID_REV  = 4'h0,
	parameter logic [15:0] ID_PART = 16'h0a5c,
	parameter logic [10:0] ID_VEND = 11'h2a5
)
(
	// Core clock and power-up reset
	input  wire logic                   core_clk,
	input  wire logic                   rst,
	// Test port
	input  wire logic                   tck,
	input  wire logic                   tms,
	input  wire logic                   tdi,
	output logic                        tdo,
	output logic                        tdo_oe_n,
	// I/O ring
	input  wire logic [`BSTP_BSR_W-1:0] ring_in,
	// Core-side status
	output logic                        core_extest,
	output logic                        core_tap_reset
);

	// ------------------------------------------------------------
	// Test clock reset
	// ------------------------------------------------------------
	// Power-up asserts at once; release is retimed to the test clock
	logic tck_rst_meta_reg;
	logic tck_rst_reg;

	always_ff @(posedge tck or posedge rst)
	begin
		if (rst)
		begin
			tck_rst_meta_reg <= 1'h1;
			tck_rst_reg      <= 1'h1;
		end
		else
		begin
			tck_rst_meta_reg <= 1'h0;
			tck_rst_reg      <= tck_rst_meta_reg;
		end
	end

	// ------------------------------------------------------------
	// Test clock domain state
	// ------------------------------------------------------------
	localparam logic [`BSTP_ID_W-1:0] ID_VALUE = {ID_REV, ID_PART, ID_VEND, `BSTP_ID_FIXVAL};

	bstp_pkg::bstp_state_t           state_reg;
	bstp_pkg::bstp_state_t           state_next;
	logic [`BSTP_IR_W-1:0]           ir_sh_reg;
	logic [`BSTP_IR_W-1:0]           ir_sh_next;
	logic [`BSTP_IR_W-1:0]           ir_reg;
	logic [`BSTP_IR_W-1:0]           ir_next;
	logic                            byp_reg;
	logic                            byp_next;
	logic [`BSTP_ID_W-1:0]           id_reg;
	logic [`BSTP_ID_W-1:0]           id_next;
	logic [`BSTP_BSR_W-1:0]          bsr_reg;
	logic [`BSTP_BSR_W-1:0]          bsr_next;
	logic [`BSTP_BSR_W-1:0]          ring_meta_reg;
	logic [`BSTP_BSR_W-1:0]          ring_sync_reg;
	logic                            extest_reg;
	logic                            extest_next;
	logic                            tlr_flag_reg;
	logic                            tlr_flag_next;
	bstp_pkg::bstp_ctl_t             ctl;
	bstp_pkg::bstp_path_t            path;
	logic                            serial_out;

	// Controller next state
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			bstp_pkg::BSTP_TLR:    state_next = tms ? bstp_pkg::BSTP_TLR    : bstp_pkg::BSTP_RTI;
			bstp_pkg::BSTP_RTI:    state_next = tms ? bstp_pkg::BSTP_SEL_DR : bstp_pkg::BSTP_RTI;
			bstp_pkg::BSTP_SEL_DR: state_next = tms ? bstp_pkg::BSTP_SEL_IR : bstp_pkg::BSTP_CAP_DR;
			bstp_pkg::BSTP_CAP_DR: state_next = tms ? bstp_pkg::BSTP_EX1_DR : bstp_pkg::BSTP_SH_DR;
			bstp_pkg::BSTP_SH_DR:  state_next = tms ? bstp_pkg::BSTP_EX1_DR : bstp_pkg::BSTP_SH_DR;
			bstp_pkg::BSTP_EX1_DR: state_next = tms ? bstp_pkg::BSTP_UPD_DR : bstp_pkg::BSTP_PAU_DR;
			bstp_pkg::BSTP_PAU_DR: state_next = tms ? bstp_pkg::BSTP_EX2_DR : bstp_pkg::BSTP_PAU_DR;
			bstp_pkg::BSTP_EX2_DR: state_next = tms ? bstp_pkg::BSTP_UPD_DR : bstp_pkg::BSTP_SH_DR;
			bstp_pkg::BSTP_UPD_DR: state_next = tms ? bstp_pkg::BSTP_SEL_DR : bstp_pkg::BSTP_RTI;
			bstp_pkg::BSTP_SEL_IR: state_next = tms ? bstp_pkg::BSTP_TLR    : bstp_pkg::BSTP_CAP_IR;
			bstp_pkg::BSTP_CAP_IR: state_next = tms ? bstp_pkg::BSTP_EX1_IR : bstp_pkg::BSTP_SH_IR;
			bstp_pkg::BSTP_SH_IR:  state_next = tms ? bstp_pkg::BSTP_EX1_IR : bstp_pkg::BSTP_SH_IR;
			bstp_pkg::BSTP_EX1_IR: state_next = tms ? bstp_pkg::BSTP_UPD_IR : bstp_pkg::BSTP_PAU_IR;
			bstp_pkg::BSTP_PAU_IR: state_next = tms ? bstp_pkg::BSTP_EX2_IR : bstp_pkg::BSTP_PAU_IR;
			bstp_pkg::BSTP_EX2_IR: state_next = tms ? bstp_pkg::BSTP_UPD_IR : bstp_pkg::BSTP_SH_IR;
			bstp_pkg::BSTP_UPD_IR: state_next = tms ? bstp_pkg::BSTP_SEL_DR : bstp_pkg::BSTP_RTI;
			default:               state_next = bstp_pkg::BSTP_TLR;
		endcase
	end

	// Strobes, path select and register next values
	always_comb
	begin
		ctl.in_reset   = (state_reg == bstp_pkg::BSTP_TLR);
		ctl.capture_dr = (state_reg == bstp_pkg::BSTP_CAP_DR);
		ctl.shift_dr   = (state_reg == bstp_pkg::BSTP_SH_DR);
		ctl.update_dr  = (state_reg == bstp_pkg::BSTP_UPD_DR);
		ctl.capture_ir = (state_reg == bstp_pkg::BSTP_CAP_IR);
		ctl.shift_ir   = (state_reg == bstp_pkg::BSTP_SH_IR);
		ctl.update_ir  = (state_reg == bstp_pkg::BSTP_UPD_IR);
		// Only the held instruction steers the data path, never the one being shifted
		if (ir_reg == `BSTP_IR_IDCODE)
			path = bstp_pkg::BSTP_P_ID;
		else if (ir_reg == `BSTP_IR_EXTEST || ir_reg == `BSTP_IR_SAMPLE)
			path = bstp_pkg::BSTP_P_BSR;
		else
			path = bstp_pkg::BSTP_P_BYP;
		ir_sh_next = ir_sh_reg;
		if (ctl.capture_ir)
			ir_sh_next = `BSTP_IR_CAPT;
		else if (ctl.shift_ir)
			ir_sh_next = {tdi, ir_sh_reg[`BSTP_IR_W-1:1]};
		ir_next = ir_reg;
		if (ctl.in_reset)
			ir_next = `BSTP_IR_IDCODE;
		else if (ctl.update_ir)
			ir_next = ir_sh_reg;
		byp_next = byp_reg;
		id_next  = id_reg;
		bsr_next = bsr_reg;
		if (ctl.capture_dr)
		begin
			case (path)
				bstp_pkg::BSTP_P_ID:  id_next  = ID_VALUE;
				bstp_pkg::BSTP_P_BSR: bsr_next = ring_sync_reg;
				default:              byp_next = `BSTP_BYP_RST;
			endcase
		end
		else if (ctl.shift_dr)
		begin
			case (path)
				bstp_pkg::BSTP_P_ID:  id_next  = {tdi, id_reg[`BSTP_ID_W-1:1]};
				bstp_pkg::BSTP_P_BSR: bsr_next = {tdi, bsr_reg[`BSTP_BSR_W-1:1]};
				default:              byp_next = tdi;
			endcase
		end
		// Status follows the edge that changes it, so a stopped test clock cannot leave it stale
		extest_next   = (ir_next == `BSTP_IR_EXTEST);
		tlr_flag_next = (state_next == bstp_pkg::BSTP_TLR);
	end

	// All test inputs are taken on the rising edge
	always_ff @(posedge tck or posedge tck_rst_reg)
	begin
		if (tck_rst_reg)
		begin
			state_reg     <= bstp_pkg::BSTP_TLR;
			ir_sh_reg     <= `BSTP_IR_CAPT;
			ir_reg        <= `BSTP_IR_IDCODE;
			byp_reg       <= `BSTP_BYP_RST;
			id_reg        <= `BSTP_ID_RST;
			bsr_reg       <= `BSTP_BSR_RST;
			ring_meta_reg <= `BSTP_BSR_RST;
			ring_sync_reg <= `BSTP_BSR_RST;
			extest_reg    <= 1'h0;
			tlr_flag_reg  <= 1'h1;
		end
		else
		begin
			state_reg     <= state_next;
			ir_sh_reg     <= ir_sh_next;
			ir_reg        <= ir_next;
			byp_reg       <= byp_next;
			id_reg        <= id_next;
			bsr_reg       <= bsr_next;
			ring_meta_reg <= ring_in;
			ring_sync_reg <= ring_meta_reg;
			extest_reg    <= extest_next;
			tlr_flag_reg  <= tlr_flag_next;
		end
	end

	// ------------------------------------------------------------
	// Serial output on the falling edge
	// ------------------------------------------------------------
	// Half a test clock of hold for the next chip in the chain
	logic tdo_reg;
	logic tdo_oe_n_reg;
	logic tdo_oe_n_next;

	always_comb
	begin
		if (ctl.shift_ir)
			serial_out = ir_sh_reg[0];
		else if (path == bstp_pkg::BSTP_P_ID)
			serial_out = id_reg[0];
		else if (path == bstp_pkg::BSTP_P_BSR)
			serial_out = bsr_reg[0];
		else
			serial_out = byp_reg;
		tdo_oe_n_next = ~(ctl.shift_ir | ctl.shift_dr);
	end

	always_ff @(negedge tck or posedge tck_rst_reg)
	begin
		if (tck_rst_reg)
		begin
			tdo_reg      <= 1'h0;
			tdo_oe_n_reg <= 1'h1;
		end
		else
		begin
			tdo_reg      <= serial_out;
			tdo_oe_n_reg <= tdo_oe_n_next;
		end
	end

	assign tdo      = tdo_reg;
	assign tdo_oe_n = tdo_oe_n_reg;

	// ------------------------------------------------------------
	// Core clock status
	// ------------------------------------------------------------
	// Levels only; a stopped test clock simply freezes them
	logic [1:0] ext_sync_reg;
	logic [1:0] ext_sync_next;
	logic [1:0] tlr_sync_reg;
	logic [1:0] tlr_sync_next;

	always_comb
	begin
		ext_sync_next = {ext_sync_reg[0], extest_reg};
		tlr_sync_next = {tlr_sync_reg[0], tlr_flag_reg};
	end

	always_ff @(posedge core_clk or posedge rst)
	begin
		if (rst)
		begin
			ext_sync_reg <= 2'h0;
			tlr_sync_reg <= 2'h3;
		end
		else
		begin
			ext_sync_reg <= ext_sync_next;
			tlr_sync_reg <= tlr_sync_next;
		end
	end

	assign core_extest    = ext_sync_reg[1];
	assign core_tap_reset = tlr_sync_reg[1];

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence s_tms_high;
		tms [*5];
	endsequence

	sequence s_cap_id;
		ctl.capture_dr && path == bstp_pkg::BSTP_P_ID;
	endsequence

	property p_five_high;
		@(posedge tck) disable iff (tck_rst_reg)
		s_tms_high |=> state_reg == bstp_pkg::BSTP_TLR;
	endproperty
	a_five_high: assert property (p_five_high) else $error("five high TMS did not reset");

	property p_ir_reset;
		@(posedge tck) disable iff (tck_rst_reg)
		ctl.in_reset |=> ir_reg == `BSTP_IR_IDCODE && path == bstp_pkg::BSTP_P_ID;
	endproperty
	a_ir_reset: assert property (p_ir_reset) else $error("reset did not load identification");

	property p_ir_shift;
		@(posedge tck) disable iff (tck_rst_reg)
		ctl.capture_ir ##1 ctl.shift_ir [*3] |=> ir_sh_reg == {$past(tdi), $past(tdi, 2), $past(tdi, 3)};
	endproperty
	a_ir_shift: assert property (p_ir_shift) else $error("instruction shift wrong");

	property p_ir_update;
		@(posedge tck) disable iff (tck_rst_reg)
		ctl.update_ir |=> ir_reg == $past(ir_sh_reg);
	endproperty
	a_ir_update: assert property (p_ir_update) else $error("instruction not taken on update");

	property p_bypass;
		@(posedge tck) disable iff (tck_rst_reg)
		ctl.shift_dr && path == bstp_pkg::BSTP_P_BYP |=> byp_reg == $past(tdi);
	endproperty
	a_bypass: assert property (p_bypass) else $error("bypass stage wrong");

	property p_id_capture;
		@(posedge tck) disable iff (tck_rst_reg)
		s_cap_id |=> id_reg == ID_VALUE && id_reg[`BSTP_ID_FIX];
	endproperty
	a_id_capture: assert property (p_id_capture) else $error("identification not captured");

	property p_id_shift;
		@(posedge tck) disable iff (tck_rst_reg)
		s_cap_id ##1 ctl.shift_dr |=> id_reg == {$past(tdi), ID_VALUE[`BSTP_ID_W-1:1]};
	endproperty
	a_id_shift: assert property (p_id_shift) else $error("identification shift wrong");

	property p_bsr_capture;
		@(posedge tck) disable iff (tck_rst_reg)
		ctl.capture_dr && path == bstp_pkg::BSTP_P_BSR |=> bsr_reg == $past(ring_sync_reg);
	endproperty
	a_bsr_capture: assert property (p_bsr_capture) else $error("ring not sampled");

	property p_bsr_shift;
		@(posedge tck) disable iff (tck_rst_reg)
		ctl.shift_dr && path == bstp_pkg::BSTP_P_BSR |=> bsr_reg == {$past(tdi), $past(bsr_reg[`BSTP_BSR_W-1:1])};
	endproperty
	a_bsr_shift: assert property (p_bsr_shift) else $error("boundary shift wrong");

	property p_undef;
		@(posedge tck) disable iff (tck_rst_reg)
		ir_reg inside {3'h3, 3'h4, 3'h5, 3'h6, 3'h7} |-> path == bstp_pkg::BSTP_P_BYP;
	endproperty
	a_undef: assert property (p_undef) else $error("undefined code not bypass");

endmodule

// *** sim/bstp_jtag_host.sv ***
// Test controller model: makes the test clock and walks the port controller.
// Assumes the bench calls its tasks; the clock stands low between frames.
`timescale 1ns/10ps

module bstp_jtag_host
(
	// Test port
	output logic      tck,
	output logic      tms,
	output logic      tdi,
	input  wire logic tdo
);
	localparam int HALF = 80;

	initial
	begin
		tck = 1'b0;
		tms = 1'b1;
		tdi = 1'b0;
	end

	// Lines change while the clock is low; tdo is taken before the rise and again before the fall
	task automatic step(input logic m, input logic d, input bit drive, output logic o, output logic h);
		tms = m;
		tdi = drive ? d : ~tdi; // Idle data line toggles so a stale bit cannot pass
		#HALF;
		o = tdo;
		tck = 1'b1;
		#(HALF - 1);
		h = tdo;
		#1;
		tck = 1'b0;
	endtask

	task automatic walk(input logic m);
		logic o;
		logic h;
		step(m, 1'b0, 1'b0, o, h);
	endtask

	// Five clocks with mode select high reach test-logic-reset from anywhere
	task automatic reset_port();
		repeat (5) walk(1'b1);
	endtask

	// From run-test/idle: one instruction or data scan of n bits, back to run-test/idle
	task automatic scan(input bit ir, input int n, input logic [159:0] din,
		output logic [159:0] dout, output logic [159:0] dhold);
		dout = '0;
		dhold = '0;
		walk(1'b1);
		if (ir)
			walk(1'b1);
		walk(1'b0);
		walk(1'b0);
		for (int i = 0; i < n; i++)
			step(i == n - 1, din[i], 1'b1, dout[i], dhold[i]);
		walk(1'b1);
		walk(1'b0);
	endtask
endmodule

// *** sim/bstp_tap_tb.sv ***
// Self-checking bench of the test access port.
// Assumes the controller model drives the test port; core clock 100 ns, test clock 160 ns.
`timescale 1ns/10ps

module bstp_tap_tb;
	typedef struct packed
	{
		logic [2:0] code;
		logic [7:0] len;
	} bstp_tb_row_t;

	localparam logic [3:0]   T_REV  = 4'h0;     // Arbitrary value, left at the design default
	localparam logic [15:0]  T_PART = 16'h5e21; // Arbitrary value
	localparam logic [10:0]  T_VEND = 11'h2a5;  // Arbitrary value, left at the design default
	localparam logic [31:0]  T_ID   = {T_REV, T_PART, T_VEND, 1'b1};
	localparam logic [159:0] PAT    = {5{32'h9e37_46b1}};
	localparam bstp_tb_row_t ROWS [8] = '{'{3'h0, 8'h6b}, '{3'h1, 8'h20}, '{3'h2, 8'h6b}, '{3'h3, 8'h01},
		'{3'h4, 8'h01}, '{3'h5, 8'h01}, '{3'h6, 8'h01}, '{3'h7, 8'h01}};

	logic           core_clk;
	logic           rst;
	logic           tck;
	logic           tms;
	logic           tdi;
	logic           tdo;
	logic           tdo_oe_n;
	logic [106:0]   ring_in;
	logic           core_extest;
	logic           core_tap_reset;
	logic [159:0]   dout;
	logic [159:0]   dhold;
	logic [159:0]   exp_v;
	int             n_errors;
	int             checks_done;

	bstp_tap #(.ID_PART(T_PART)) dut_u
	(
		.core_clk       (core_clk),
		.rst            (rst),
		.tck            (tck),
		.tms            (tms),
		.tdi            (tdi),
		.tdo            (tdo),
		.tdo_oe_n       (tdo_oe_n),
		.ring_in        (ring_in),
		.core_extest    (core_extest),
		.core_tap_reset (core_tap_reset)
	);

	bstp_jtag_host host_u
	(
		.tck (tck),
		.tms (tms),
		.tdi (tdi),
		.tdo (tdo)
	);

	initial
	begin
		core_clk = 1'b0;
	end

	always #50 core_clk = ~core_clk;

	task automatic core_wait(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic chk_bit(input string what, input logic e, input logic g);
		checks_done++;
		if (e !== g)
		begin
			n_errors++;
			$display("Error %s expected %b seen %b", what, e, g);
		end
	endtask

	task automatic chk_vec(input string what, input int n, input logic [159:0] e, input logic [159:0] g);
		logic [159:0] m;
		m = {160{1'b1}} >> (160 - n);
		checks_done++;
		if ((e & m) !== (g & m))
		begin
			n_errors++;
			$display("Error %s expected %h seen %h", what, e & m, g & m);
		end
	endtask

	task automatic print_verdict();
		if (n_errors == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Power-up reset, then the identification code must come out without any instruction load
	task automatic power_up();
		core_wait(1);
		rst = 1'b1;
		core_wait(16);
		chk_bit("tdo", 1'b0, tdo);
		chk_bit("tdo_oe_n", 1'b1, tdo_oe_n);
		chk_bit("core_tap_reset", 1'b1, core_tap_reset);
		chk_bit("core_extest", 1'b0, core_extest);
		rst = 1'b0;
		host_u.reset_port();
		host_u.walk(1'b0);
		host_u.scan(1'b0, 64, PAT, dout, dhold);
		chk_vec("idcode", 64, {128'h0, T_ID} | (PAT << 32), dout);
	endtask

	initial
	begin
		#2_000_000;
		n_errors++;
		$display("Error watchdog expected done seen timeout");
		print_verdict();
	end

	initial
	begin
		n_errors = 0;
		checks_done = 0;
		rst = 1'b0;
		ring_in = {3'h5, {13{8'hc3}}};
		power_up();
		// Every instruction code, each followed by a data scan long enough to see the path length
		foreach (ROWS[r])
		begin
			ring_in = ~ring_in;
			host_u.scan(1'b1, 3, {157'h0, ROWS[r].code}, dout, dhold);
			chk_vec("ir_capture", 3, 160'h1, dout);
			core_wait(4);
			chk_bit("core_extest", ROWS[r].code === 3'h0, core_extest);
			exp_v = (ROWS[r].len == 8'h6b) ? {53'h0, ring_in} : (ROWS[r].len == 8'h20) ? {128'h0, T_ID} : '0;
			exp_v = exp_v | (PAT << ROWS[r].len);
			host_u.scan(1'b0, 140, PAT, dout, dhold);
			chk_vec("dr_scan", 140, exp_v, dout);
			chk_vec("tdo_high", 140, exp_v, dhold);
		end
		// Four mode-select clocks from shift-DR fall one short of test-logic-reset
		host_u.walk(1'b1);
		host_u.walk(1'b0);
		host_u.walk(1'b0);
		core_wait(1);
		chk_bit("tdo_oe_n", 1'b0, tdo_oe_n);
		repeat (4) host_u.walk(1'b1);
		core_wait(4);
		chk_bit("tdo_oe_n", 1'b1, tdo_oe_n);
		chk_bit("core_tap_reset", 1'b0, core_tap_reset);
		host_u.walk(1'b1);
		core_wait(4);
		chk_bit("core_tap_reset", 1'b1, core_tap_reset);
		host_u.walk(1'b0);
		host_u.scan(1'b0, 64, PAT, dout, dhold);
		chk_vec("idcode_after_tms", 64, {128'h0, T_ID} | (PAT << 32), dout);
		// Second power-up reset while the boundary test instruction is held
		host_u.scan(1'b1, 3, 160'h0, dout, dhold);
		core_wait(4);
		chk_bit("core_extest", 1'b1, core_extest);
		power_up();
		print_verdict();
	end
endmodule
